// ==== shared/fwd_ctrl_consts.svh ====
`ifndef FWD_CTRL_CONSTS_SVH
`define FWD_CTRL_CONSTS_SVH

// Register offsets on the management register port
`define CTRL_ONE_OFFSET 8'h03
`define CTRL_TWO_OFFSET 8'h04

// Control one fields
`define C1_FRAME_LEN_CHECK 3
`define C1_AGING_EN 2
`define C1_FAST_AGE_EN 1
`define C1_AGGR_BACKOFF 0
// Control one reset value; bit 0 comes from the mode strap
`define C1_RESET 8'h34

// Control two fields
`define C2_VLAN_MISMATCH_DISCARD 7
`define C2_MCAST_STORM_DISABLE 6
`define C2_BP_MODE 5
`define C2_FAIR_MODE 4
`define C2_NO_EXCESS_COLL_DROP 3
`define C2_HUGE_PKT 2
`define C2_LEGAL_SIZE_CHECK 1
`define C2_PRIO_BUF_RESERVE 0
// Control two reset value; bits 3 and 1 come from straps
`define C2_RESET 8'hF1

// Frame limits
`define LEN_TYPE_LIMIT 16'h05DC
`define HUGE_MAX_BYTES 11'h77C
`define TAGGED_MAX_BYTES 11'h5F2
`define UNTAGGED_MAX_BYTES 11'h5EE
`define DEFAULT_MAX_BYTES 11'h600
`define EXCESS_COLL_COUNT 5'h10

// Timing
`define CLK_PERIOD_NS 100
`define FAST_AGE_US 800
`define NORMAL_AGE_S 200
`define FAST_AGE_CYC ((`FAST_AGE_US * 1000) / `CLK_PERIOD_NS)
`define NORMAL_AGE_CYC ((64'd`NORMAL_AGE_S * 64'd1_000_000_000) / 64'd`CLK_PERIOD_NS)

`endif

// ==== shared/fwd_ctrl_pkg.sv ====
`default_nettype none

package fwd_ctrl_pkg;

  // Why a frame was refused; earliest listed reason wins when several apply
  typedef enum logic [1:0] {
    DROP_NONE,
    DROP_LENGTH_FIELD,
    DROP_OVERSIZE,
    DROP_VLAN_BOUNDARY
  } drop_reason_t;

endpackage

`default_nettype wire

// ==== rtl/age_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

// Address aging period divider: one-cycle tick per aging period
module age_tick_gen #(
  parameter logic [31:0] FAST_CYCLES = 32'h0000_1F40,
  parameter logic [31:0] NORMAL_CYCLES = 32'h7735_9400
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic enable_in,
  input wire logic fast_in,
  output logic tick_out
);

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;
  logic [31:0] limit;

  always_comb begin
    limit = fast_in ? FAST_CYCLES : NORMAL_CYCLES;
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (!enable_in) begin
      nxt_cnt = 32'h0000_0000;
    end else if (cnt_ff >= limit - 32'h0000_0001) begin
      nxt_cnt = 32'h0000_0000;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_out = tick_ff;

endmodule // age_tick_gen

`default_nettype wire

// ==== rtl/switch_global_forwarding_control.sv ====
// Overview of operation
// - Length checking on drops frames whose length field below 1500 mismatches.
// - Address aging runs only while aging enable is set; default set.
// - Fast age selects an aging period of about 800 microseconds.
// - Aggressive back-off for half duplex; default from mode strap at reset.
// - Discard set blocks all VLAN crossing; clear lets known unicast cross.
// - Port mirroring is withheld while the mismatch discard field is clear.
// - Storm disable set: only all-ones destination frames are counted.
// - Storm disable clear: destination bit 40 frames are also counted.
// - Back pressure mode: set is carrier sense, clear is collision based.
// - Fair mode drops non-flow-controlled source traffic under contention.
// - Fair mode off pauses the flow-controlled source under contention.
// - No-excessive-collision-drop keeps frames after 16 collisions; strap default.
// - Huge packet support accepts frames up to 1916 bytes inclusive.
// - Huge packet support overrides the legal size check field.
// - Legal check off allows 1536; on allows 1522 tagged, 1518 untagged.
// - Normal aging period is about 200 seconds.
`timescale 1ns/1ps
`default_nettype none
`include "fwd_ctrl_consts.svh"

module switch_global_forwarding_control
  import fwd_ctrl_pkg::*;
#(
  parameter logic [31:0] FAST_AGE_CYCLES = 32'(`FAST_AGE_CYC),
  parameter logic [31:0] NORMAL_AGE_CYCLES = 32'(`NORMAL_AGE_CYC)
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Reset-time straps
  input wire logic mac_mode_strap_pin_in,
  input wire logic legal_size_strap_in,
  // Management register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Received frame descriptor
  input wire logic frm_valid_in,
  input wire logic [10:0] frm_size_in,
  input wire logic [15:0] frm_len_type_in,
  input wire logic [15:0] frm_data_len_in,
  input wire logic frm_tagged_in,
  input wire logic frm_da_all_ones_in,
  input wire logic frm_da_bit40_in,
  input wire logic frm_known_ucast_in,
  input wire logic frm_vlan_cross_in,
  input wire logic frm_mirror_req_in,
  // Frame verdict
  output logic verdict_valid_out,
  output logic verdict_accept_out,
  output logic [1:0] verdict_reason_out,
  output logic mirror_out,
  output logic storm_count_out,
  // Transmit collision handling
  input wire logic tx_coll_valid_in,
  input wire logic [4:0] tx_coll_cnt_in,
  output logic tx_drop_out,
  output logic tx_retry_out,
  // Egress contention between flow-controlled and plain sources
  input wire logic contention_in,
  output logic pause_fc_src_out,
  output logic drop_nfc_src_out,
  // Mode levels to the MAC logic, and the one-cycle aging tick
  output logic aggr_backoff_out,
  output logic bp_carrier_sense_out,
  output logic age_tick_out
);

  logic [7:0] ctrl_one_ff;
  logic [7:0] ctrl_two_ff;
  logic [7:0] nxt_ctrl_one;
  logic [7:0] nxt_ctrl_two;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic wr_one;
  logic wr_two;
  logic [7:0] ctrl_one_rst;
  logic [7:0] ctrl_two_rst;

  // Strap-merged defaults, taken on every edge while reset is high
  always_comb begin
    ctrl_one_rst = `C1_RESET;
    ctrl_one_rst[`C1_AGGR_BACKOFF] = mac_mode_strap_pin_in;
    ctrl_two_rst = `C2_RESET;
    ctrl_two_rst[`C2_NO_EXCESS_COLL_DROP] = mac_mode_strap_pin_in;
    ctrl_two_rst[`C2_LEGAL_SIZE_CHECK] = legal_size_strap_in;
  end

  assign wr_one = reg_wr_in && (reg_addr_in == `CTRL_ONE_OFFSET);
  assign wr_two = reg_wr_in && (reg_addr_in == `CTRL_TWO_OFFSET);

  // Register access; a read beside a write to the same address returns the old value
  always_comb begin
    nxt_ctrl_one = ctrl_one_ff;
    nxt_ctrl_two = ctrl_two_ff;
    nxt_rdata = rdata_ff;
    nxt_rvalid = reg_rd_in;
    if (wr_one) begin
      nxt_ctrl_one = reg_wdata_in;
    end
    if (wr_two) begin
      nxt_ctrl_two = reg_wdata_in;
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `CTRL_ONE_OFFSET: nxt_rdata = ctrl_one_ff;
        `CTRL_TWO_OFFSET: nxt_rdata = ctrl_two_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_one_ff <= ctrl_one_rst;
      ctrl_two_ff <= ctrl_two_rst;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      ctrl_one_ff <= nxt_ctrl_one;
      ctrl_two_ff <= nxt_ctrl_two;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign reg_rvalid_out = rvalid_ff;

  // Field views
  logic len_check_en;
  logic aging_en;
  logic fast_age_en;
  logic vlan_discard;
  logic mcast_storm_off;
  logic fair_mode;
  logic keep_excess_coll;
  logic huge_en;
  logic legal_check_en;
  logic aggr_backoff_en;
  logic bp_carrier_sense;

  assign len_check_en = ctrl_one_ff[`C1_FRAME_LEN_CHECK];
  assign aging_en = ctrl_one_ff[`C1_AGING_EN];
  assign fast_age_en = ctrl_one_ff[`C1_FAST_AGE_EN];
  assign vlan_discard = ctrl_two_ff[`C2_VLAN_MISMATCH_DISCARD];
  assign mcast_storm_off = ctrl_two_ff[`C2_MCAST_STORM_DISABLE];
  assign fair_mode = ctrl_two_ff[`C2_FAIR_MODE];
  assign keep_excess_coll = ctrl_two_ff[`C2_NO_EXCESS_COLL_DROP];
  assign huge_en = ctrl_two_ff[`C2_HUGE_PKT];
  assign legal_check_en = ctrl_two_ff[`C2_LEGAL_SIZE_CHECK];
  assign aggr_backoff_en = ctrl_one_ff[`C1_AGGR_BACKOFF];
  assign bp_carrier_sense = ctrl_two_ff[`C2_BP_MODE];

  // Frame verdict
  logic verdict_valid_ff;
  logic verdict_accept_ff;
  drop_reason_t reason_ff;
  logic mirror_ff;
  logic storm_ff;
  logic nxt_verdict_valid;
  logic nxt_verdict_accept;
  drop_reason_t nxt_reason;
  logic nxt_mirror;
  logic nxt_storm;
  logic [10:0] max_size;
  logic len_err;
  logic size_err;
  logic vlan_err;
  logic frame_ok;

  always_comb begin
    len_err = len_check_en && (frm_len_type_in < `LEN_TYPE_LIMIT)
              && (frm_len_type_in != frm_data_len_in);
    if (huge_en) begin
      max_size = `HUGE_MAX_BYTES;
    end else if (legal_check_en) begin
      max_size = frm_tagged_in ? `TAGGED_MAX_BYTES : `UNTAGGED_MAX_BYTES;
    end else begin
      max_size = `DEFAULT_MAX_BYTES;
    end
    size_err = frm_size_in > max_size;
    vlan_err = frm_vlan_cross_in && (vlan_discard || !frm_known_ucast_in);
    frame_ok = !len_err && !size_err && !vlan_err;
    nxt_verdict_valid = frm_valid_in;
    nxt_verdict_accept = 1'b0;
    nxt_reason = DROP_NONE;
    nxt_mirror = 1'b0;
    nxt_storm = 1'b0;
    // Reasons are exclusive; the first failing check is reported
    if (frm_valid_in) begin
      if (len_err) begin
        nxt_reason = DROP_LENGTH_FIELD;
      end else if (size_err) begin
        nxt_reason = DROP_OVERSIZE;
      end else if (vlan_err) begin
        nxt_reason = DROP_VLAN_BOUNDARY;
      end else begin
        nxt_verdict_accept = 1'b1;
      end
      nxt_mirror = frm_mirror_req_in && vlan_discard && frame_ok;
      nxt_storm = frm_da_all_ones_in || (!mcast_storm_off && frm_da_bit40_in);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      verdict_valid_ff <= 1'b0;
      verdict_accept_ff <= 1'b0;
      reason_ff <= DROP_NONE;
      mirror_ff <= 1'b0;
      storm_ff <= 1'b0;
    end else begin
      verdict_valid_ff <= nxt_verdict_valid;
      verdict_accept_ff <= nxt_verdict_accept;
      reason_ff <= nxt_reason;
      mirror_ff <= nxt_mirror;
      storm_ff <= nxt_storm;
    end
  end

  // Verdict stands for the one cycle after the descriptor
  assign verdict_valid_out = verdict_valid_ff;
  assign verdict_accept_out = verdict_accept_ff;
  assign verdict_reason_out = reason_ff;
  assign mirror_out = mirror_ff;
  assign storm_count_out = storm_ff;

  // Collision, contention and mode levels
  logic tx_drop_ff;
  logic tx_retry_ff;
  logic pause_ff;
  logic nfc_drop_ff;
  logic aggr_ff;
  logic bp_cs_ff;
  logic nxt_tx_drop;
  logic nxt_tx_retry;
  logic nxt_pause;
  logic nxt_nfc_drop;
  logic excess;
  logic nxt_aggr;
  logic nxt_bp_cs;

  always_comb begin
    // Sixteen or more collisions count as excessive
    excess = tx_coll_cnt_in >= `EXCESS_COLL_COUNT;
    nxt_tx_drop = tx_coll_valid_in && excess && !keep_excess_coll;
    nxt_tx_retry = tx_coll_valid_in && (!excess || keep_excess_coll);
    nxt_nfc_drop = contention_in && fair_mode;
    nxt_pause = contention_in && !fair_mode;
    nxt_aggr = aggr_backoff_en;
    nxt_bp_cs = bp_carrier_sense;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_drop_ff <= 1'b0;
      tx_retry_ff <= 1'b0;
      pause_ff <= 1'b0;
      nfc_drop_ff <= 1'b0;
      aggr_ff <= 1'b0;
      bp_cs_ff <= 1'b0;
    end else begin
      tx_drop_ff <= nxt_tx_drop;
      tx_retry_ff <= nxt_tx_retry;
      pause_ff <= nxt_pause;
      nfc_drop_ff <= nxt_nfc_drop;
      aggr_ff <= nxt_aggr;
      bp_cs_ff <= nxt_bp_cs;
    end
  end

  assign tx_drop_out = tx_drop_ff;
  assign tx_retry_out = tx_retry_ff;
  assign pause_fc_src_out = pause_ff;
  assign drop_nfc_src_out = nfc_drop_ff;
  assign aggr_backoff_out = aggr_ff;
  assign bp_carrier_sense_out = bp_cs_ff;

  // Aging period
  // Count restarts whenever aging is switched off
  age_tick_gen #(
    .FAST_CYCLES(FAST_AGE_CYCLES),
    .NORMAL_CYCLES(NORMAL_AGE_CYCLES)
  ) u_age_tick (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(aging_en),
    .fast_in(fast_age_en),
    .tick_out(age_tick_out)
  );

endmodule // switch_global_forwarding_control

`default_nettype wire

// ==== sim/fwd_ctrl_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module fwd_ctrl_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic frm_valid_in,
  input wire logic [10:0] frm_size_in,
  input wire logic [15:0] frm_len_type_in,
  input wire logic frm_da_all_ones_in,
  input wire logic frm_known_ucast_in,
  input wire logic frm_vlan_cross_in,
  input wire logic verdict_valid_out,
  input wire logic verdict_accept_out,
  input wire logic mirror_out,
  input wire logic storm_count_out,
  input wire logic tx_coll_valid_in,
  input wire logic [4:0] tx_coll_cnt_in,
  input wire logic tx_drop_out,
  input wire logic tx_retry_out,
  input wire logic contention_in,
  input wire logic pause_fc_src_out,
  input wire logic drop_nfc_src_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_frm(c);
    frm_valid_in && c;
  endsequence
  property p_lat; s_frm(1'b1) |=> verdict_valid_out; endproperty
  a_lat: assert property (p_lat) else $error("verdict late");
  property p_huge; s_frm(frm_size_in > 11'h77C) |=> !verdict_accept_out; endproperty
  a_huge: assert property (p_huge) else $error("oversize kept");
  property p_small; s_frm(frm_size_in <= 11'h5EE && !frm_vlan_cross_in && frm_len_type_in >= 16'h05DC)
    |=> verdict_accept_out; endproperty
  a_small: assert property (p_small) else $error("legal frame dropped");
  property p_vlan; s_frm(frm_vlan_cross_in && !frm_known_ucast_in) |=> !verdict_accept_out; endproperty
  a_vlan: assert property (p_vlan) else $error("unknown crossed boundary");
  property p_mirror; mirror_out |-> verdict_valid_out && verdict_accept_out; endproperty
  a_mirror: assert property (p_mirror) else $error("mirror without accept");
  property p_storm; s_frm(frm_da_all_ones_in) |=> storm_count_out; endproperty
  a_storm: assert property (p_storm) else $error("broadcast not counted");
  property p_coll; tx_coll_valid_in && tx_coll_cnt_in < 5'h10 |=> tx_retry_out && !tx_drop_out; endproperty
  a_coll: assert property (p_coll) else $error("frame dropped early");
  property p_cont; contention_in |=> pause_fc_src_out ^ drop_nfc_src_out; endproperty
  a_cont: assert property (p_cont) else $error("contention action wrong");
endmodule // fwd_ctrl_chk
bind switch_global_forwarding_control fwd_ctrl_chk chk_i (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .frm_valid_in(frm_valid_in), .frm_size_in(frm_size_in),
  .frm_len_type_in(frm_len_type_in), .frm_da_all_ones_in(frm_da_all_ones_in),
  .frm_known_ucast_in(frm_known_ucast_in), .frm_vlan_cross_in(frm_vlan_cross_in),
  .verdict_valid_out(verdict_valid_out), .verdict_accept_out(verdict_accept_out), .mirror_out(mirror_out),
  .storm_count_out(storm_count_out), .tx_coll_valid_in(tx_coll_valid_in), .tx_coll_cnt_in(tx_coll_cnt_in),
  .tx_drop_out(tx_drop_out), .tx_retry_out(tx_retry_out), .contention_in(contention_in),
  .pause_fc_src_out(pause_fc_src_out), .drop_nfc_src_out(drop_nfc_src_out)
);
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [7:0] c1, c2;
    logic [10:0] sz;
    logic [15:0] lt, dl;
    logic [4:0] fl;
    logic [3:0] ex;
  } row_t;
  logic clk_in = '0, sys_rst_in = '1, mac_mode_strap_pin_in = '1, legal_size_strap_in = '0;
  logic reg_wr_in = '0, reg_rd_in = '0, frm_valid_in = '0, frm_tagged_in = '0, frm_da_all_ones_in = '0;
  logic frm_da_bit40_in = '0, frm_known_ucast_in = '0, frm_vlan_cross_in = '0, frm_mirror_req_in = '1;
  logic tx_coll_valid_in = '0, contention_in = '0, reg_rvalid_out, verdict_valid_out, verdict_accept_out;
  logic mirror_out, storm_count_out, tx_drop_out, tx_retry_out, pause_fc_src_out, drop_nfc_src_out;
  logic aggr_backoff_out, bp_carrier_sense_out, age_tick_out;
  logic [7:0] reg_addr_in = '0, reg_wdata_in = '0, reg_rdata_out;
  logic [10:0] frm_size_in = '0;
  logic [15:0] frm_len_type_in = '0, frm_data_len_in = '0;
  logic [4:0] tx_coll_cnt_in = '0;
  logic [1:0] verdict_reason_out;
  int mismatches = 0, tests_run = 0, k;
  // Fields: ctrl one, ctrl two, size, len/type, data len, {tag,ones,b40,ucast,cross}, {accept,reason,storm}
  row_t rows [18] = '{
    {8'h05, 8'hF0, 11'h600, 16'h0800, 16'h0000, 5'h00, 4'h8}, {8'h04, 8'hF0, 11'h601, 16'h0800, 16'h0000, 5'h00, 4'h4},
    {8'h04, 8'hF2, 11'h5EE, 16'h0800, 16'h0000, 5'h00, 4'h8}, {8'h04, 8'hF2, 11'h5EF, 16'h0800, 16'h0000, 5'h00, 4'h4},
    {8'h04, 8'hF2, 11'h5F2, 16'h0800, 16'h0000, 5'h10, 4'h8}, {8'h04, 8'hF2, 11'h5F3, 16'h0800, 16'h0000, 5'h10, 4'h4},
    {8'h04, 8'hF6, 11'h77C, 16'h0800, 16'h0000, 5'h00, 4'h8}, {8'h04, 8'hF6, 11'h77D, 16'h0800, 16'h0000, 5'h00, 4'h4},
    {8'h0C, 8'hF0, 11'h064, 16'h0064, 16'h0063, 5'h00, 4'h2}, {8'h0C, 8'hF0, 11'h064, 16'h0064, 16'h0064, 5'h00, 4'h8},
    {8'h0C, 8'hF0, 11'h064, 16'h05DC, 16'h0005, 5'h00, 4'h8}, {8'h04, 8'hF0, 11'h064, 16'h0064, 16'h0063, 5'h00, 4'h8},
    {8'h04, 8'hF0, 11'h064, 16'h0800, 16'h0000, 5'h03, 4'h6}, {8'h04, 8'h70, 11'h064, 16'h0800, 16'h0000, 5'h03, 4'h8},
    {8'h04, 8'h70, 11'h064, 16'h0800, 16'h0000, 5'h01, 4'h6}, {8'h04, 8'hF0, 11'h064, 16'h0800, 16'h0000, 5'h08, 4'h9},
    {8'h04, 8'hD0, 11'h064, 16'h0800, 16'h0000, 5'h04, 4'h8},
    {8'h04, 8'hB0, 11'h064, 16'h0800, 16'h0000, 5'h04, 4'h9}};
  always #50 clk_in = ~clk_in;
  switch_global_forwarding_control #(.FAST_AGE_CYCLES(32'h0000_0014), .NORMAL_AGE_CYCLES(32'h0000_0032)) DUT (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .mac_mode_strap_pin_in(mac_mode_strap_pin_in),
    .legal_size_strap_in(legal_size_strap_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .frm_valid_in(frm_valid_in), .frm_size_in(frm_size_in),
    .frm_len_type_in(frm_len_type_in), .frm_data_len_in(frm_data_len_in), .frm_tagged_in(frm_tagged_in),
    .frm_da_all_ones_in(frm_da_all_ones_in), .frm_da_bit40_in(frm_da_bit40_in),
    .frm_known_ucast_in(frm_known_ucast_in), .frm_vlan_cross_in(frm_vlan_cross_in),
    .frm_mirror_req_in(frm_mirror_req_in), .verdict_valid_out(verdict_valid_out),
    .verdict_accept_out(verdict_accept_out), .verdict_reason_out(verdict_reason_out), .mirror_out(mirror_out),
    .storm_count_out(storm_count_out), .tx_coll_valid_in(tx_coll_valid_in), .tx_coll_cnt_in(tx_coll_cnt_in),
    .tx_drop_out(tx_drop_out), .tx_retry_out(tx_retry_out), .contention_in(contention_in),
    .pause_fc_src_out(pause_fc_src_out), .drop_nfc_src_out(drop_nfc_src_out),
    .aggr_backoff_out(aggr_backoff_out), .bp_carrier_sense_out(bp_carrier_sense_out),
    .age_tick_out(age_tick_out)
  );
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step;
    @(posedge clk_in);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    step();
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    step();
    reg_wr_in = 1'b0;
    step();
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    step();
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    step();
    reg_rd_in = 1'b0;
    chk("rvalid", reg_rvalid_out, 16'h0001);
    chk("rdata", reg_rdata_out, e);
  endtask
  task automatic frame(row_t r);
    step();
    {frm_tagged_in, frm_da_all_ones_in, frm_da_bit40_in, frm_known_ucast_in, frm_vlan_cross_in} = r.fl;
    frm_size_in = r.sz;
    frm_len_type_in = r.lt;
    frm_data_len_in = r.dl;
    frm_valid_in = 1'b1;
    step();
    frm_valid_in = 1'b0;
    chk("verdict", {verdict_valid_out, verdict_accept_out, verdict_reason_out, storm_count_out}, {1'b1, r.ex});
    chk("mirror", mirror_out, r.ex[3] & r.c2[7] & frm_mirror_req_in);
  endtask
  task automatic coll(logic [4:0] n, logic [1:0] e);
    step();
    tx_coll_cnt_in = n;
    tx_coll_valid_in = 1'b1;
    step();
    tx_coll_valid_in = 1'b0;
    chk("coll", {tx_drop_out, tx_retry_out}, e);
  endtask
  task automatic ticks(int w);
    k = 0;
    repeat (w) begin
      step();
      if (age_tick_out === 1'b1) k++;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    rd(8'h03, 8'h35);
    rd(8'h04, 8'hF9);
    rd(8'h10, 8'h00);
    $display("reset defaults done");
    for (int i = 0; i < 18; i++) begin
      wr(8'h03, rows[i].c1);
      wr(8'h04, rows[i].c2);
      chk("bp", bp_carrier_sense_out, rows[i].c2[5]);
      chk("aggr", aggr_backoff_out, rows[i].c1[0]);
      frame(rows[i]);
    end
    rd(8'h04, 8'hB0);
    frm_mirror_req_in = 1'b0;
    frame(rows[15]);
    frm_mirror_req_in = 1'b1;
    step();
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = {8'h04, 8'hF1, 2'b11};
    step();
    {reg_wr_in, reg_rd_in} = 2'b00;
    chk("clash", reg_rdata_out, 16'h00B0);
    rd(8'h04, 8'hF1);
    $display("frame table done");
    ticks(200);
    chk("normal", 16'(k inside {[3:4]}), 16'h0001);
    wr(8'h03, 8'h06);
    ticks(25);
    ticks(200);
    chk("fast", 16'(k inside {[9:10]}), 16'h0001);
    wr(8'h03, 8'h00);
    ticks(200);
    chk("off", 16'(k), 16'h0000);
    $display("aging done");
    wr(8'h04, 8'hF9);
    coll(5'h10, 2'b01);
    coll(5'h1F, 2'b01);
    wr(8'h04, 8'hF1);
    coll(5'h0F, 2'b01);
    coll(5'h10, 2'b10);
    contention_in = 1'b1;
    step();
    step();
    chk("fair", {pause_fc_src_out, drop_nfc_src_out}, 16'h0001);
    wr(8'h04, 8'hE1);
    chk("unfair", {pause_fc_src_out, drop_nfc_src_out}, 16'h0002);
    contention_in = 1'b0;
    $display("collision and contention done");
    sys_rst_in = 1'b1;
    mac_mode_strap_pin_in = 1'b0;
    legal_size_strap_in = 1'b1;
    repeat (5) step();
    sys_rst_in = 1'b0;
    wr(8'h10, 8'hFF);
    rd(8'h03, 8'h34);
    rd(8'h04, 8'hF3);
    chk("aggr", aggr_backoff_out, 16'h0000);
    $display("second reset done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
